// *** logic/tbs_channel.sv ***
/*
 one channel of the transmit pulse sequencer: delay count, then shifts
 the pattern lsb first onto the positive and negative drives.
 assumes launch is a one-cycle pulse and the gate level is already synced.
*/
`timescale 1ns/10ps
module tbs_channel (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               gate_on,
   input  wire logic               launch,
   input  wire tbs_pkg::tbs_delay_t delay,
   input  wire logic [63:0]        pos_pat,
   input  wire logic [63:0]        neg_pat,
   input  wire logic               invert,
   input  wire logic               cw,
   input  wire logic [6:0]         len_n,
   input  wire logic [10:0]        period,
   output logic                    pos_drive,
   output logic                    neg_drive,
   output logic                    busy
);

   typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_SHIFT, CH_DONE} tbs_ch_state_t;

   tbs_ch_state_t state_reg;
   logic [16:0]   cnt_reg;
   logic [5:0]    bit_reg;
   logic [10:0]   phase_reg;
   logic          adj;
   logic [10:0]   k;
   logic          last_phase;
   logic          last_bit;
   logic          pos_bit;
   logic          neg_bit;
   logic          in_window;
   logic [16:0]   dcount;

   assign adj        = delay.adj_en == tbs_pkg::ADJ_ON; // [R03]
   assign k          = {8'h00, delay.adj_amt};
   assign dcount     = {delay.coarse, delay.fine}; // [R04] [R22]
   assign last_phase = phase_reg == period - 11'h001; // [R11]
   assign last_bit   = {1'b0, bit_reg} == len_n - 7'h01; // [R12] [R24]
   assign pos_bit    = pos_pat[bit_reg] ^ invert; // [R18] [R21]
   assign neg_bit    = neg_pat[bit_reg] ^ invert;
   assign in_window  = phase_reg >= k && phase_reg + k < period; // [R01]
   assign busy       = state_reg == CH_WAIT || state_reg == CH_SHIFT;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= CH_IDLE;
         cnt_reg   <= 17'h00000;
         bit_reg   <= 6'h00;
         phase_reg <= 11'h000;
      end
      else if (!gate_on)
      begin
         state_reg <= CH_IDLE; // [R25]
         bit_reg   <= 6'h00;
         phase_reg <= 11'h000;
      end
      else
      begin
         unique case (state_reg)
            CH_IDLE:
               if (launch)
               begin
                  cnt_reg   <= dcount; // [R05]
                  state_reg <= (dcount == 17'h00000) ? CH_SHIFT : CH_WAIT;
               end
            CH_WAIT:
            begin
               cnt_reg <= cnt_reg - 17'h00001;
               if (cnt_reg == 17'h00001)
                  state_reg <= CH_SHIFT; // [R15]
            end
            CH_SHIFT:
               if (last_phase)
               begin
                  phase_reg <= 11'h000;
                  if (!last_bit)
                     bit_reg <= bit_reg + 6'h01;
                  else if (cw)
                     bit_reg <= 6'h00; // [R08]
                  else
                     state_reg <= CH_DONE;
               end
               else
                  phase_reg <= phase_reg + 11'h001;
            CH_DONE:
               state_reg <= CH_DONE;
         endcase
      end
   end

   // drive outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pos_drive <= 1'b0;
         neg_drive <= 1'b0;
      end
      else
      begin
         pos_drive <= gate_on && state_reg == CH_SHIFT && pos_bit
                      && (!adj || (in_window && !neg_bit)); // [R01] [R02]
         neg_drive <= gate_on && state_reg == CH_SHIFT && neg_bit;
      end
   end

   no_overlap_a: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      adj |-> !(pos_drive && neg_drive))
      else $error("drives overlap with adjust on");

   quiet_gate_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [R25]
      !gate_on ##1 !gate_on |=> !pos_drive && !neg_drive)
      else $error("drive active while gate low");

   delay_expiry_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (gate_on && state_reg == CH_WAIT && cnt_reg == 17'h00001) |=> state_reg == CH_SHIFT)
      else $error("pattern did not start at delay end");

   cw_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      (gate_on && cw && state_reg == CH_SHIFT && last_phase && last_bit) ##1 gate_on
      |-> state_reg == CH_SHIFT && bit_reg == 6'h00)
      else $error("continuous pattern did not wrap");

   finite_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (gate_on && !cw && state_reg == CH_SHIFT && last_phase && last_bit) ##1 gate_on
      |-> state_reg == CH_DONE)
      else $error("finite pattern did not stop at length");

   adjust_fire_c: cover property (@(posedge pclk) disable iff (!presetn)
      adj && pos_drive ##1 !pos_drive);

endmodule

// *** logic/tbs_pkg.sv ***
/*
 package of the transmit pulse sequencer: register indices, field layouts,
 reset values, timing counts and shared helper functions.
 assumes one clock; pclk stands in for the internal fast clock and one
 pclk cycle stands in for one fine delay step.
*/
package tbs_pkg;

   localparam int NUM_CH = 8;
   localparam int PAT_W  = 64;

   // channel delay word, msb first
   typedef struct packed {
      logic [1:0]  adj_en;
      logic [2:0]  adj_amt;
      logic [13:0] coarse;
      logic [2:0]  fine;
   } tbs_delay_t;

   // firing configuration word, 14 bits, loop enable at bit 10
   typedef struct packed {
      logic        rsvd;
      logic        cw;
      logic        alt;
      logic        loop_en;
      logic [6:0]  div;
      logic [2:0]  len;
   } tbs_cfg_t;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DELAY0 = 8'h00;
   localparam logic [7:0] IDX_DELAY7 = 8'h07;
   localparam logic [7:0] IDX_POS    = 8'h18;
   localparam logic [7:0] IDX_NEG    = 8'h19;
   localparam logic [7:0] IDX_CFG    = 8'h1a;
   localparam logic [7:0] IDX_POS_HI = 8'h20;
   localparam logic [7:0] IDX_NEG_HI = 8'h21;
   localparam logic [7:0] IDX_STATUS = 8'h22;

   localparam logic [1:0]  ADJ_ON       = 2'h2;
   localparam logic [2:0]  FIRE_LATENCY = 3'h6;
   localparam logic [10:0] DIV_ZERO_AS  = 11'h080;
   localparam int          MCLK_SHIFT   = 3;

   localparam logic [63:0] CW_POS    = 64'h5555555555555555;
   localparam logic [63:0] CW_NEG    = 64'haaaaaaaaaaaaaaaa;
   localparam logic [21:0] DELAY_RST = 22'h000000;
   localparam logic [13:0] CFG_RST   = 14'h0000;
   localparam logic [63:0] PAT_RST   = 64'h0000000000000000;

   // status word fields
   localparam int ST_GATE  = 0;
   localparam int ST_INV   = 1;
   localparam int ST_BUSY  = 2;
   localparam int ST_LOOP  = 10;
   localparam int ST_ARMED = 11;

   // length code to bit count: 000 4, 001 8, 010 16, 011 32, 1xx 64
   function automatic logic [6:0] len_bits(input logic [2:0] code);
      len_bits = code[2] ? 7'h40 : (7'h04 << code[1:0]);
   endfunction

   // bit period in fine steps: divider master periods of 8 fine steps
   function automatic logic [10:0] bit_period(input logic [6:0] div);
      logic [10:0] d;
      d = (div == 7'h00) ? DIV_ZERO_AS : {4'h0, div};
      bit_period = d << MCLK_SHIFT;
   endfunction

endpackage

// *** logic/tbs_sequencer.sv ***
/*
 top of the eight-channel transmit pulse sequencer: apb register file,
 fire gate synchroniser, start latency, polarity alternation, channels.
 assumes an apb3 master on pclk and a fire gate pin from outside the domain.
*/
// Summary of operation
// R01: with adjust on, positive drive starts k fine steps late, 2k shorter.
// R02: with adjust on, positive and negative drives never overlap.
// R03: adjust field 00 disables adjust; 10 enables it.
// R04: delay word holds adjust enable, adjust amount, coarse count, fine count.
// R05: programmed delay is counted after a fixed start latency.
// R06: continuous mode uses preset patterns 1,0 positive and 0,1 negative.
// R07: continuous mode ignores writes to shared pattern registers.
// R08: continuous mode repeats the pattern with no gap.
// R09: configuration is 14 bits: reserved, cw, alternate, loop, divider, length.
// R10: continuous bit 1 selects continuous firing, 0 finite firing.
// R11: each pattern bit lasts divider master clock periods.
// R12: length code 000 fires 4 bits, 001 fires 8 bits.
// R13: delay registers keep contents across firings and mode changes.
// R14: after gate rise, wait 6 internal cycles before counting delay.
// R15: pattern starts when the delay count reaches its programmed value.
// R16: controller holds the fire gate high until every channel finished.
// R17: alternate mode fires plain then inverted on successive transmissions; the design never inverts in continuous mode.
// R18: next gate rise after a plain firing outputs the inverted pattern; in continuous mode the design outputs it plain.
// R19: without the alternate bit every firing is plain.
// R20: controller lowers the gate between firings for reception.
// R21: pattern bits go out lsb first up to the programmed length.
// R22: one coarse step is eight fine steps.
// R23: loop enable is bit 10 of configuration; firing needs it set.
// R24: length code 111 selects 64 bits.
// R25: gate low returns channels to idle with drives inactive.
`timescale 1ns/10ps
module tbs_sequencer #(
   parameter int NUM_CH = tbs_pkg::NUM_CH
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              fire_gate,
   output logic      [NUM_CH-1:0] pos_drive,
   output logic      [NUM_CH-1:0] neg_drive
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   tbs_pkg::tbs_delay_t delay_reg [NUM_CH];
   tbs_pkg::tbs_cfg_t   cfg_reg;
   logic [63:0]         pos_pat_reg;
   logic [63:0]         neg_pat_reg;
   logic [31:0]         prdata_reg;
   logic [31:0]         rd_next;
   logic [31:0]         status;
   logic [7:0]          idx;
   logic                aligned;
   logic                hit;
   logic                wr_en;
   logic                rd_setup;
   logic [2:0]          sync_reg;
   logic                gate_reg;
   logic                gate_prev_reg;
   logic                gate_rise;
   logic                gate_fall;
   logic [2:0]          lat_reg;
   logic                launch;
   logic                armed_reg;
   logic                fired_reg;
   logic                inv_reg;
   logic                invert;
   logic [63:0]         pos_sel;
   logic [63:0]         neg_sel;
   logic [6:0]          len_n;
   logic [10:0]         period;
   logic [NUM_CH-1:0]   busy;

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   assign idx      = {2'h0, paddr[7:2]};
   assign aligned  = paddr[1:0] == 2'h0;
   assign hit      = aligned && (idx <= tbs_pkg::IDX_DELAY7
                                 || idx == tbs_pkg::IDX_POS
                                 || idx == tbs_pkg::IDX_NEG
                                 || idx == tbs_pkg::IDX_CFG
                                 || idx == tbs_pkg::IDX_POS_HI
                                 || idx == tbs_pkg::IDX_NEG_HI
                                 || idx == tbs_pkg::IDX_STATUS);
   assign wr_en    = psel && penable && pwrite && hit;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !hit;
   assign prdata   = prdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // delay registers, kept until reset

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_CH; i++)
            delay_reg[i] <= tbs_pkg::DELAY_RST;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
            if (wr_en && idx == tbs_pkg::IDX_DELAY0 + 8'(i))
               delay_reg[i] <= pwdata[21:0]; // [R04] [R13]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration register

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= tbs_pkg::CFG_RST;
      else if (wr_en && idx == tbs_pkg::IDX_CFG)
      begin
         cfg_reg      <= pwdata[13:0]; // [R09] [R10] [R23]
         cfg_reg.rsvd <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared pattern registers, locked in continuous mode

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pos_pat_reg <= tbs_pkg::PAT_RST;
         neg_pat_reg <= tbs_pkg::PAT_RST;
      end
      else if (wr_en && !cfg_reg.cw) // [R07]
      begin
         if (idx == tbs_pkg::IDX_POS)
            pos_pat_reg[31:0] <= pwdata;
         if (idx == tbs_pkg::IDX_POS_HI)
            pos_pat_reg[63:32] <= pwdata;
         if (idx == tbs_pkg::IDX_NEG)
            neg_pat_reg[31:0] <= pwdata;
         if (idx == tbs_pkg::IDX_NEG_HI)
            neg_pat_reg[63:32] <= pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux and read data register

   always_comb
   begin
      status                        = 32'h00000000;
      status[tbs_pkg::ST_GATE]      = gate_reg;
      status[tbs_pkg::ST_INV]       = invert;
      status[tbs_pkg::ST_BUSY +: 8] = 8'(busy);
      status[tbs_pkg::ST_LOOP]      = cfg_reg.loop_en;
      status[tbs_pkg::ST_ARMED]     = armed_reg;
      rd_next                       = 32'h00000000;
      if (idx <= tbs_pkg::IDX_DELAY7)
         rd_next = {10'h000, delay_reg[idx[2:0]]};
      else if (idx == tbs_pkg::IDX_POS)
         rd_next = pos_pat_reg[31:0];
      else if (idx == tbs_pkg::IDX_POS_HI)
         rd_next = pos_pat_reg[63:32];
      else if (idx == tbs_pkg::IDX_NEG)
         rd_next = neg_pat_reg[31:0];
      else if (idx == tbs_pkg::IDX_NEG_HI)
         rd_next = neg_pat_reg[63:32];
      else if (idx == tbs_pkg::IDX_CFG)
         rd_next = {18'h00000, cfg_reg};
      else if (idx == tbs_pkg::IDX_STATUS)
         rd_next = status;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h00000000;
      else if (rd_setup)
         prdata_reg <= (aligned && hit) ? rd_next : 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // fire gate synchroniser: third and second stage must agree

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_reg <= 3'h0;
      else
         sync_reg <= {sync_reg[1:0], fire_gate};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_reg      <= 1'b0;
         gate_prev_reg <= 1'b0;
      end
      else
      begin
         if (sync_reg[1] == sync_reg[2])
            gate_reg <= sync_reg[2];
         gate_prev_reg <= gate_reg;
      end
   end

   assign gate_rise = gate_reg && !gate_prev_reg;
   assign gate_fall = !gate_reg && gate_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // start latency after gate rise

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lat_reg <= 3'h0;
      else if (!gate_reg)
         lat_reg <= 3'h0;
      else if (gate_rise && cfg_reg.loop_en) // [R23]
         lat_reg <= tbs_pkg::FIRE_LATENCY; // [R14]
      else if (lat_reg != 3'h0)
         lat_reg <= lat_reg - 3'h1;
   end

   assign launch = gate_reg && lat_reg == 3'h1; // [R05] [R14]

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         armed_reg <= 1'b0;
      else if (!gate_reg)
         armed_reg <= 1'b0;
      else if (gate_rise && cfg_reg.loop_en)
         armed_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // polarity alternation between transmissions

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fired_reg <= 1'b0;
      else if (gate_fall)
         fired_reg <= 1'b0;
      else if (launch)
         fired_reg <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         inv_reg <= 1'b0;
      else if (!cfg_reg.alt)
         inv_reg <= 1'b0; // [R19]
      else if (gate_fall && fired_reg)
         inv_reg <= !inv_reg; // [R17] [R18]
   end

   assign invert = inv_reg && !cfg_reg.cw;

   ////////////////////////////////////////////////////////////////////////
   // pattern and timing selection

   assign pos_sel = cfg_reg.cw ? tbs_pkg::CW_POS : pos_pat_reg; // [R06] [R10]
   assign neg_sel = cfg_reg.cw ? tbs_pkg::CW_NEG : neg_pat_reg;
   assign len_n   = tbs_pkg::len_bits(cfg_reg.len); // [R12] [R24]
   assign period  = tbs_pkg::bit_period(cfg_reg.div); // [R11]

   ////////////////////////////////////////////////////////////////////////
   // channels

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      tbs_channel u_ch (
         .pclk      (pclk),
         .presetn   (presetn),
         .gate_on   (gate_reg),
         .launch    (launch),
         .delay     (delay_reg[c]),
         .pos_pat   (pos_sel),
         .neg_pat   (neg_sel),
         .invert    (invert),
         .cw        (cfg_reg.cw),
         .len_n     (len_n),
         .period    (period),
         .pos_drive (pos_drive[c]),
         .neg_drive (neg_drive[c]),
         .busy      (busy[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   start_latency_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      (gate_rise && cfg_reg.loop_en) ##1 gate_reg [*5] |=> launch)
      else $error("launch not six cycles after gate rise");

   no_early_launch_a: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
      gate_rise |-> !launch ##1 !launch [*4])
      else $error("launch before start latency");

   cw_pattern_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      (wr_en && cfg_reg.cw) |=> pos_pat_reg == $past(pos_pat_reg)
                               && neg_pat_reg == $past(neg_pat_reg))
      else $error("pattern changed in continuous mode");

   cfg_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      !cfg_reg.rsvd)
      else $error("reserved configuration bit set");

   invert_toggle_a: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      (gate_fall && fired_reg && cfg_reg.alt) ##1 cfg_reg.alt
      |-> inv_reg != $past(inv_reg))
      else $error("polarity did not alternate");

   plain_only_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      !cfg_reg.alt |=> !inv_reg || cfg_reg.alt)
      else $error("inverted firing without alternate mode");

   delay_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      !(wr_en && idx <= tbs_pkg::IDX_DELAY7)
      |=> delay_reg[0] == $past(delay_reg[0]) && delay_reg[7] == $past(delay_reg[7]))
      else $error("delay word changed without a write");

   cw_firing_c: cover property (@(posedge pclk) disable iff (!presetn)
      cfg_reg.cw && launch ##[1:300] pos_drive[0]);

   inverted_firing_c: cover property (@(posedge pclk) disable iff (!presetn)
      invert && launch);

   finite_firing_c: cover property (@(posedge pclk) disable iff (!presetn)
      !cfg_reg.cw && launch ##[1:300] neg_drive[0]);

endmodule

// *** tb/tb_top.sv ***
/*
 testbench of the pulse sequencer: apb register access and fire gate shots.
 assumes an apb slave on pclk and the pulser model on the drives.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
   begin n_tests++; if ((gt) !== (ex)) \
   begin err_count++; $display("Error %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fire_gate = 1'b0;
   logic [7:0]  pos_drive;
   logic [7:0]  neg_drive;
   logic        overlap;
   logic [7:0]  pa [0:299];
   logic [7:0]  na [0:299];
   logic [31:0] q;
   logic        e;
   int          err_count = 0;
   int          n_tests = 0;
   always #5 pclk = ~pclk;
   tbs_sequencer #(.NUM_CH(8)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fire_gate(fire_gate),
      .pos_drive(pos_drive), .neg_drive(neg_drive));
   tbs_pulser_model pm_u (.pclk(pclk), .pos_drive(pos_drive), .neg_drive(neg_drive),
      .overlap(overlap));
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the edge at which pready is sampled high
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // first active cycle: sel 0 pos, 1 neg, 2 either
   function automatic int first(input int ch, input int sel);
      for (int i = 0; i < 300; i++)
         if ((sel != 1 && pa[i][ch] === 1'b1) || (sel != 0 && na[i][ch] === 1'b1))
            return i;
      return 0;
   endfunction
   function automatic int cnt(input int ch, input int sel, input int lo, input int hi);
      int c;
      c = 0;
      for (int i = lo; i < hi; i++)
         c += (sel == 0) ? int'(pa[i][ch] === 1'b1) : int'(na[i][ch] === 1'b1);
      return c;
   endfunction
   // gate held n+1 cycles, 300 cycles captured
   task automatic fire(input int n);
      @(posedge pclk);
      fire_gate <= 1'b1;
      for (int i = 0; i < 300; i++)
      begin
         @(posedge pclk);
         pa[i] = pos_drive;
         na[i] = neg_drive;
         if (i == n)
            fire_gate <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      `CHK("idle drives", 16'h0, {pos_drive, neg_drive})
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic regs_check();
      apb(1'b1, 8'h68, 32'hffffffff);
      apb(1'b0, 8'h68, 32'h0);
      `CHK("cfg", 32'h1fff, q)
      apb(1'b1, 8'h04, 32'hffffffff);
      apb(1'b0, 8'h04, 32'h0);
      `CHK("delay", 32'h3fffff, q)
      apb(1'b0, 8'h90, 32'h0);
      `CHK("unmapped", 1'b1, e)
      apb(1'b1, 8'h68, 32'h8);
      apb(1'b1, 8'h60, 32'hf5);
      apb(1'b1, 8'h64, 32'h0a);
      apb(1'b1, 8'h04, 32'h11);
      fire(100);
      `CHK("loop off", 0, cnt(0, 2, 0, 300) + cnt(0, 0, 0, 300))
   endtask
   task automatic finite_shot();
      apb(1'b1, 8'h68, 32'h408);
      fire(100);
      `CHK("bits", 16, cnt(0, 0, 0, 300))
      `CHK("lsb first", first(0, 0) + 8, first(0, 1))
      `CHK("ch1 start", first(0, 0) + 17, first(1, 0))
      `CHK("latency", 12, first(0, 0))
      apb(1'b1, 8'h68, 32'h409);
      fire(100);
      `CHK("bits 8", 48, cnt(0, 0, 0, 300))
      apb(1'b1, 8'h68, 32'h408);
   endtask
   task automatic adjust_shot();
      apb(1'b1, 8'h00, 32'h260000);
      apb(1'b1, 8'h04, 32'h060000);
      fire(100);
      `CHK("adj width", 4, cnt(0, 0, 0, 300))
      `CHK("adj start", first(1, 0) + 3, first(0, 0))
      `CHK("adj off", 16, cnt(1, 0, 0, 300))
      `CHK("overlap", 1'b0, overlap)
   endtask
   task automatic cw_shot();
      int f;
      apb(1'b1, 8'h68, 32'h1408);
      apb(1'b1, 8'h60, 32'h0);
      apb(1'b0, 8'h60, 32'h0);
      `CHK("cw lock", 32'hf5, q)
      fire(290);
      f = first(1, 2);
      `CHK("cw pos", 1'b1, pa[f][1])
      `CHK("cw neg", 1'b1, na[f + 8][1])
      `CHK("cw pos run", 128, cnt(1, 0, f, f + 256))
      `CHK("cw neg run", 128, cnt(1, 1, f, f + 256))
      apb(1'b0, 8'h00, 32'h0);
      `CHK("delay kept", 32'h260000, q)
   endtask
   task automatic invert_shot();
      apb(1'b1, 8'h68, 32'hc08);
      fire(100);
      `CHK("plain", 1'b1, pa[first(1, 2)][1])
      apb(1'b1, 8'h68, 32'h408);
      fire(100);
      `CHK("alt off", 1'b1, pa[first(1, 2)][1])
      apb(1'b1, 8'h68, 32'hc08);
      fire(100);
      fire(100);
      `CHK("inverted", 1'b1, na[first(1, 2)][1])
   endtask
   task automatic conclude();
      if (err_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      regs_check();
      finite_shot();
      adjust_shot();
      cw_shot();
      invert_shot();
      conclude();
   end
   initial
   begin
      #200us;
      err_count++;
      conclude();
   end
endmodule

// *** tb/tbs_pulser_model.sv ***
/*
 high-voltage pulser model: watches both drive buses, flags shoot-through.
 assumes drives are registered on pclk and zero out of reset.
*/
`timescale 1ns/10ps
module tbs_pulser_model (
   input  wire logic       pclk,
   input  wire logic [7:0] pos_drive,
   input  wire logic [7:0] neg_drive,
   output logic            overlap
);
   initial overlap = 1'b0;
   // both halves on at once would short the high-voltage rails
   always @(posedge pclk)
      if ((pos_drive & neg_drive) !== 8'h00)
      begin
         overlap <= 1'b1;
      end
endmodule
